// *** bench/phase_resync_timer_tb.sv ***
// self-checking bench: apb host shifts words to the timer
// assumes prt_pkg, the interface and both ends compiled first
`timescale 1ns/10ps
`default_nettype none
`include "prt_regs.svh"
module phase_resync_timer_tb;
  import prt_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`PRT_HOST_AW-1:0] paddr = 12'h000;
  prt_word_t pwdata = 32'h0;
  prt_word_t prdata, rd, cap;
  logic pready, pslverr, busy, err, sync_pulse, resync_pulse;
  logic resync_active, mod_valid, mod_carry;
  logic sclk_q = 1'b0;
  prt_field_t phase_state;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int nbits = 0;
  int t1, t2, n;
  // table: modulus, dither, function, legal modulus
  prt_field_t mtab [5] = '{12'h001, 12'h002, 12'h031, 12'h032, 12'hFFF};
  logic dtab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [1:0] ftab [5] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h0};
  logic vtab [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  // table: divider, phase word, expected seed (modulus 5)
  prt_field_t dvtab [3] = '{12'h001, 12'h003, 12'h002};
  prt_field_t ptab [3] = '{12'h003, 12'h004, 12'h007};
  prt_field_t stab [3] = '{12'h003, 12'h004, 12'h000};
  prt_if prt_if_inst ();
  prt_host #(.HALF_DIV(2)) prt_host_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .link(prt_if_inst));
  prt_device prt_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(prt_if_inst), .sync_pulse(sync_pulse),
    .resync_pulse(resync_pulse), .resync_active(resync_active),
    .mod_valid(mod_valid), .phase_state(phase_state),
    .mod_carry(mod_carry));
  prt_assertions prt_assertions_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .sclk(prt_if_inst.sclk), .sdata(prt_if_inst.sdata),
    .load_strobe(prt_if_inst.load_strobe), .busy(busy),
    .sync_pulse(sync_pulse), .resync_pulse(resync_pulse),
    .resync_active(resync_active));
  // ---------------------------------------------------------------
  // clock, timeout and link monitor
  // ---------------------------------------------------------------
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  // cut a hang short well past the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // collect the bits the device takes on sclk rises
  always @(posedge ref_clk)
  begin
    sclk_q <= prt_if_inst.sclk;
    if (!prt_if_inst.load_strobe && prt_if_inst.sclk && !sclk_q)
    begin
      cap <= {cap[30:0], prt_if_inst.sdata};
      nbits <= nbits + 1;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input prt_word_t got, input prt_word_t exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; waits for pready, result in rd and err
  // only the bench timeout ends a wait for a missing pready
  task automatic apb(input logic wr, input logic [11:0] a,
    input prt_word_t d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // send one word, wait for the frame end, compare the wire
  task automatic send(input prt_word_t w);
    int k;
    apb(1'b1, `PRT_OFS_DATA, w);
    nbits = 0;
    apb(1'b1, `PRT_OFS_CTRL, 32'h0000_0001);
    k = 0;
    while (busy !== 1'b0 && k < 1000)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(cap, w);
    chk(nbits, 32'h0000_0020);
  endtask : send
  // cycles until the next sync pulse
  task automatic wait_sync(output int t);
    t = 0;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (sync_pulse !== 1'b1 && t < 500);
  endtask : wait_sync
  function automatic prt_word_t w1(input prt_field_t ph, input prt_field_t m);
    return {5'h00, ph, m, 3'h1};
  endfunction : w1
  function automatic prt_word_t w3(input logic d, input logic [1:0] f,
    input prt_field_t v);
    return {13'h0000, d, 1'b0, f, v, 3'h3};
  endfunction : w3
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // status idle after reset, unmapped place refused
    apb(1'b0, `PRT_OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    // fraction numerator 1, then done flag after the frame
    send({17'h00000, 12'h001, 3'h0});
    apb(1'b0, `PRT_OFS_STAT, 32'h0);
    chk(rd, 32'h0000_0002);
    // data register reads back the word last written
    apb(1'b0, `PRT_OFS_DATA, 32'h0);
    chk(rd, {17'h00000, 12'h001, 3'h0});
    // modulus limits and every function code
    for (int i = 0; i < 5; i++)
    begin
      send(w1(12'h000, mtab[i]));
      send(w3(dtab[i], ftab[i], 12'h001));
      repeat (3) @(posedge ref_clk);
      chk(mod_valid, vtab[i]);
      chk(resync_active, ftab[i] == 2'h2 && vtab[i]);
    end
    // realign on the second sync after each strobe rise
    for (int i = 0; i < 3; i++)
    begin
      n = int'(dvtab[i]) * 5;
      send(w1(ptab[i], 12'h005));
      send(w3(1'b0, 2'h2, dvtab[i]));
      wait_sync(t1);
      chk(t1 >= n && t1 <= n + 4, 32'h1);
      chk(resync_pulse, 32'h0);
      wait_sync(t2);
      chk(t2, n);
      chk(resync_pulse, 32'h1);
      chk(phase_state, stab[i]);
      wait_sync(t2);
      chk(resync_pulse, 32'h0);
      // numerator 1 over modulus 5: one carry in every five cycles
      n = 0;
      repeat (25)
      begin
        @(posedge ref_clk);
        n += int'(mod_carry);
      end
      chk(n, 32'h0000_0005);
    end
    wrap_up();
  end
endmodule : phase_resync_timer_tb
`default_nettype wire

// *** bench/prt_assertions.sv ***
// checker for the serial link and the timer outputs
// assumes the bench instantiates it beside the link interface
`timescale 1ns/10ps
`default_nettype none
module prt_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic busy,
  input wire logic sync_pulse,
  input wire logic resync_pulse,
  input wire logic resync_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // helper: sclk rises counted within one frame
  // ---------------------------------------------------------------
  logic sclk_r; // sclk one cycle ago
  logic [5:0] nbit_r; // rises seen since strobe fell
  // delayed serial clock for edge detection
  always_ff @(posedge ref_clk)
  begin
    sclk_r <= sclk;
  end
  // count cleared whenever the strobe is high
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || load_strobe)
      nbit_r <= 6'h00;
    else if (sclk && !sclk_r)
      nbit_r <= nbit_r + 6'h01;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_idle_low;
    load_strobe |-> !sclk;
  endproperty
  property p_data_held;
    sclk && sclk_r |-> $stable(sdata);
  endproperty
  property p_frame_bits;
    $rose(load_strobe) |-> nbit_r == 6'h20;
  endproperty
  property p_busy_end;
    $rose(load_strobe) |-> !busy && $past(busy);
  endproperty
  property p_busy_frame;
    !load_strobe |-> busy;
  endproperty
  property p_resync_on_sync;
    resync_pulse |-> sync_pulse;
  endproperty
  property p_sync_gap;
    sync_pulse |=> !sync_pulse;
  endproperty
  property p_sync_active;
    sync_pulse |-> resync_active || $past(resync_active);
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("sclk moved while strobe high");
  a_data_held: assert property (p_data_held)
    else $error("sdata changed while sclk high");
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame did not carry 32 bits");
  a_busy_end: assert property (p_busy_end)
    else $error("strobe rose out of step with busy");
  a_busy_frame: assert property (p_busy_frame)
    else $error("strobe low while host idle");
  a_resync_on_sync: assert property (p_resync_on_sync)
    else $error("realign without sync");
  a_sync_gap: assert property (p_sync_gap)
    else $error("sync pulses back to back");
  a_sync_active: assert property (p_sync_active)
    else $error("sync while timer disabled");
  // main scenarios reached
  c_frame: cover property ($rose(load_strobe));
  c_resync: cover property (resync_pulse);
  c_sync_only: cover property (sync_pulse && !resync_pulse);
endmodule : prt_assertions
`default_nettype wire

// *** common/prt_if.sv ***
// three-wire serial link between host and phase resync timer
// assumes both ends run on the same ref_clk
`timescale 1ns/10ps
`default_nettype none
interface prt_if;
  logic sclk; // serial clock, made by the host
  logic sdata; // serial data, msb first
  logic load_strobe; // low while shifting, rising edge latches
  modport host (output sclk, output sdata, output load_strobe);
  modport dev (input sclk, input sdata, input load_strobe);
endinterface : prt_if
`default_nettype wire

// *** common/prt_pkg.sv ***
// types shared by the phase resync timer and its serial host
// assumes prt_regs.svh is on the include path
`include "prt_regs.svh"
package prt_pkg;
  // one serial control word
  typedef logic [`PRT_WORD_W-1:0] prt_word_t;
  // one 12-bit count field
  typedef logic [11:0] prt_field_t;
  // host sequencer states, one-hot
  typedef enum logic [3:0] {
    PRT_IDLE = 4'h1,
    PRT_LOW = 4'h2,
    PRT_SHIFT = 4'h4,
    PRT_RAISE = 4'h8
  } prt_state_t;
endpackage : prt_pkg

// *** common/prt_regs.svh ***
// constants of the phase resync timer: link word layout and host map
// assumes nothing; included by bare name by package and modules
`ifndef PRT_REGS_SVH
`define PRT_REGS_SVH

// ---------------------------------------------------------------
// serial control word layout
// ---------------------------------------------------------------
`define PRT_WORD_W 32
`define PRT_ADDR_HI 2
`define PRT_ADDR_LO 0
`define PRT_ADDR_FRACTION_NUMERATOR 3'h0
`define PRT_ADDR_MOD 3'h1
`define PRT_ADDR_CLKDIV 3'h3
`define PRT_FIELD_HI 14
`define PRT_FIELD_LO 3
`define PRT_PHASE_HI 26
`define PRT_PHASE_LO 15
`define PRT_FUNC_HI 16
`define PRT_FUNC_LO 15
`define PRT_FUNC_RESYNC 2'h2
`define PRT_DITHER_BIT 18
`define PRT_WORD_RST 32'h0000_0000
`define PRT_MOD_MIN 12'h002
`define PRT_MOD_MIN_DITHER 12'h032
`define PRT_LFSR_SEED 12'hACE
`define PRT_LFSR_TAPS 12'h829

// ---------------------------------------------------------------
// host register map (byte addresses on the bus)
// ---------------------------------------------------------------
`define PRT_HOST_AW 12
`define PRT_OFS_DATA 12'h000
`define PRT_OFS_CTRL 12'h004
`define PRT_OFS_STAT 12'h008
`define PRT_CTRL_GO 0
`define PRT_STAT_BUSY 0
`define PRT_STAT_DONE 1
`define PRT_BIT_LAST 5'h1F
`define PRT_HALF_DIV 8

`endif

// *** src/prt_device.sv ***
// phase resync timer: serial word latches, sync timer, modulator seed
// assumes link pins synchronous to ref_clk, which is the pfd rate
//
// Behaviour
// - dither off: seed modulator from phase word
// - resync gives repeatable output phase offset with dither off
// - resync enabled only when function field is 10
// - sync spacing is divider times modulus cycles
// - divider is 12 bits, values 1 to 4095
// - modulus comes from first control word field
// - realign on second sync after strobe rise
// - host sets period above worst lock time
// - phase steps one modulus fraction per count
// - host keeps phase word fixed without table
// - shift bits on sclk rise, latch on strobe
// - host drives serial port with cpha zero
// - host drops strobe before shifting a word
// - host sends word as four bytes
// - host raises strobe after fourth byte
// - modulus 2 to 4095, 50 with dither
// - modulator and timer step each pfd cycle
`timescale 1ns/10ps
`default_nettype none
`include "prt_regs.svh"
module prt_device (
  input wire logic ref_clk,
  input wire logic sys_rst,
  prt_if.dev link,
  output logic sync_pulse,
  output logic resync_pulse,
  output logic resync_active,
  output logic mod_valid,
  output prt_pkg::prt_field_t phase_state,
  output logic mod_carry
);
  import prt_pkg::*;

  // ---------------------------------------------------------------
  // serial receiver
  // ---------------------------------------------------------------
  logic sclk_d_r; // sclk one cycle ago
  logic le_d_r; // strobe one cycle ago
  prt_word_t shift_r; // collected bits
  logic sclk_rise; // sclk rising edge
  logic le_rise; // strobe rising edge

  assign sclk_rise = link.sclk && !sclk_d_r;
  assign le_rise = link.load_strobe && !le_d_r;

  // edge history of the link pins
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sclk_d_r <= 1'b0;
      le_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= link.sclk;
      le_d_r <= link.load_strobe;
    end
  end

  // shift one bit per sclk rise, msb first
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      shift_r <= `PRT_WORD_RST;
    else if (sclk_rise && !link.load_strobe)
      shift_r <= {shift_r[`PRT_WORD_W-2:0], link.sdata};
  end

  // ---------------------------------------------------------------
  // control word latches
  // ---------------------------------------------------------------
  prt_word_t fraction_numerator_word_r; // fraction numerator word
  prt_word_t mod_word_r; // modulus and phase word
  prt_word_t div_word_r; // divider, function, dither word
  logic [2:0] waddr; // address of collected word

  assign waddr = shift_r[`PRT_ADDR_HI:`PRT_ADDR_LO];

  // strobe rise moves the word to its addressed latch
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fraction_numerator_word_r <= `PRT_WORD_RST;
      mod_word_r <= `PRT_WORD_RST;
      div_word_r <= `PRT_WORD_RST;
    end
    else if (le_rise)
    begin
      if (waddr == `PRT_ADDR_FRACTION_NUMERATOR)
        fraction_numerator_word_r <= shift_r;
      else if (waddr == `PRT_ADDR_MOD)
        mod_word_r <= shift_r;
      else if (waddr == `PRT_ADDR_CLKDIV)
        div_word_r <= shift_r;
    end
  end

  // ---------------------------------------------------------------
  // fields and validity
  // ---------------------------------------------------------------
  prt_field_t modulus; // fractional_modulus
  prt_field_t numer; // fraction_numerator
  prt_field_t phase_word; // programmed phase word
  prt_field_t clk_div; // resync interval divider
  logic dither_en; // low spur mode
  logic resync_en; // resync function selected
  logic mod_ok; // modulus usable in this mode
  logic timer_en; // sync timer runs

  assign modulus = mod_word_r[`PRT_FIELD_HI:`PRT_FIELD_LO];
  assign phase_word = mod_word_r[`PRT_PHASE_HI:`PRT_PHASE_LO];
  assign numer = fraction_numerator_word_r[`PRT_FIELD_HI:`PRT_FIELD_LO];
  assign clk_div = div_word_r[`PRT_FIELD_HI:`PRT_FIELD_LO];
  assign dither_en = div_word_r[`PRT_DITHER_BIT];
  assign resync_en =
    (div_word_r[`PRT_FUNC_HI:`PRT_FUNC_LO] == `PRT_FUNC_RESYNC);
  // dither raises the least modulus
  assign mod_ok = dither_en ? (modulus >= `PRT_MOD_MIN_DITHER)
    : (modulus >= `PRT_MOD_MIN);
  // a divider of zero is outside its range and stops the timer
  assign timer_en = resync_en && mod_ok && (clk_div != 12'h000);

  // ---------------------------------------------------------------
  // sync timer: modulus cycles times divider
  // ---------------------------------------------------------------
  prt_field_t cnt_mod_r; // pfd cycles within one modulus
  prt_field_t cnt_div_r; // moduli within one interval
  logic mod_wrap; // modulus count ends
  logic sync; // interval ends this cycle

  assign mod_wrap = (cnt_mod_r == modulus - 12'h001);
  assign sync = timer_en && mod_wrap
    && (cnt_div_r == clk_div - 12'h001);

  // count one step per pfd cycle; restart on strobe rise
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || le_rise || !timer_en)
    begin
      cnt_mod_r <= 12'h000;
      cnt_div_r <= 12'h000;
    end
    else if (mod_wrap)
    begin
      cnt_mod_r <= 12'h000;
      if (sync)
        cnt_div_r <= 12'h000;
      else
        cnt_div_r <= cnt_div_r + 12'h001;
    end
    else
      cnt_mod_r <= cnt_mod_r + 12'h001;
  end

  // ---------------------------------------------------------------
  // realign on the second sync after a strobe rise
  // ---------------------------------------------------------------
  logic armed_r; // waiting for realign
  logic seen_r; // first sync already passed
  logic realign; // realign this cycle

  assign realign = sync && armed_r && seen_r;

  // arm on strobe rise, count syncs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      armed_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else if (le_rise)
    begin
      armed_r <= 1'b1;
      seen_r <= 1'b0;
    end
    else if (sync && armed_r)
    begin
      seen_r <= 1'b1;
      if (seen_r)
        armed_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // modulator seed and phase accumulator
  // ---------------------------------------------------------------
  prt_field_t lfsr_r; // dither source
  prt_field_t acc_r; // modulator phase state
  logic carry_r;
  prt_field_t seed; // value loaded on reseed
  logic reseed; // load seed this cycle
  logic [12:0] sum; // next state before wrap

  // a phase word at or above the modulus folds to zero
  assign seed = dither_en ? ((lfsr_r < modulus) ? lfsr_r : 12'h000)
    : ((phase_word < modulus) ? phase_word : 12'h000);
  // resync seeds on realign; otherwise each new word seeds at once
  assign reseed = resync_en ? realign : le_rise;
  assign sum = {1'b0, acc_r} + {1'b0, numer};

  // dither lfsr steps every cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      lfsr_r <= `PRT_LFSR_SEED;
    else if (lfsr_r[0])
      lfsr_r <= (lfsr_r >> 1) ^ `PRT_LFSR_TAPS;
    else
      lfsr_r <= lfsr_r >> 1;
  end

  // accumulator advances by the numerator each pfd cycle; holds while the modulus is unusable
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      acc_r <= 12'h000;
      carry_r <= 1'b0;
    end
    else if (reseed)
    begin
      acc_r <= seed;
      carry_r <= 1'b0;
    end
    else if (!mod_ok)
      carry_r <= 1'b0;
    else if (sum >= {1'b0, modulus})
    begin
      acc_r <= 12'(sum - {1'b0, modulus});
      carry_r <= 1'b1;
    end
    else
    begin
      acc_r <= sum[11:0];
      carry_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic sync_r;
  logic resync_r;
  logic active_r;
  logic valid_r;

  // status and event outputs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_r <= 1'b0;
      resync_r <= 1'b0;
      active_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      sync_r <= sync;
      resync_r <= realign;
      active_r <= timer_en;
      valid_r <= mod_ok;
    end
  end

  assign sync_pulse = sync_r;
  assign resync_pulse = resync_r;
  assign resync_active = active_r;
  assign mod_valid = valid_r;
  assign phase_state = acc_r;
  assign mod_carry = carry_r;

endmodule : prt_device
`default_nettype wire

// *** src/prt_host.sv ***
// serial host: takes a word over apb and shifts it to the timer
// assumes apb master and the timer share ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "prt_regs.svh"
module prt_host #(
  parameter int HALF_DIV = `PRT_HALF_DIV // ref_clk cycles per half sclk
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PRT_HOST_AW-1:0] paddr,
  input wire prt_pkg::prt_word_t pwdata,
  output prt_pkg::prt_word_t prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  prt_if.host link
);
  import prt_pkg::*;

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  generate
    if (HALF_DIV < 1 || HALF_DIV > 255)
    begin : g_bad_div
      $error("prt_host: HALF_DIV out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  prt_word_t data_r; // word to send
  logic done_r; // last word finished
  prt_word_t prdata_r; // read data, staged in setup
  logic err_r; // unmapped address seen in setup
  prt_state_t state_r; // sequencer state
  logic wr_go; // go request accepted
  logic acc; // access phase
  logic mapped; // address decodes

  assign acc = psel && penable;
  assign mapped = (paddr == `PRT_OFS_DATA) || (paddr == `PRT_OFS_CTRL)
    || (paddr == `PRT_OFS_STAT);
  assign pready = acc; // zero wait states
  assign pslverr = acc && err_r;
  assign prdata = prdata_r;
  assign busy = (state_r != PRT_IDLE);
  // go is ignored while a word is still going out
  assign wr_go = acc && pwrite && (paddr == `PRT_OFS_CTRL)
    && pwdata[`PRT_CTRL_GO] && !busy;

  // read data and error staged in the setup cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      prdata_r <= `PRT_WORD_RST;
      err_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      err_r <= !mapped;
      if (pwrite || !mapped)
        prdata_r <= `PRT_WORD_RST;
      else if (paddr == `PRT_OFS_DATA)
        prdata_r <= data_r;
      else if (paddr == `PRT_OFS_STAT)
        prdata_r <= {30'h0000_0000, done_r, busy};
      else
        prdata_r <= `PRT_WORD_RST;
    end
  end

  // data word register; held while busy
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      data_r <= `PRT_WORD_RST;
    else if (acc && pwrite && paddr == `PRT_OFS_DATA && !busy)
      data_r <= pwdata;
  end

  // ---------------------------------------------------------------
  // sclk divider and shift sequencer
  // ---------------------------------------------------------------
  logic [7:0] div_r; // half period counter
  logic tick; // half period elapsed
  logic [4:0] bit_r; // bit being sent, 31 first
  logic sclk_r;
  logic sdata_r;
  logic le_r;

  assign tick = (div_r == 8'(HALF_DIV - 1));

  // divider, restarted by go
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || wr_go || tick)
      div_r <= 8'h00;
    else if (busy)
      div_r <= div_r + 8'h01;
  end

  // sequencer: strobe low, 32 cpha=0 bits as four bytes, strobe high
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= PRT_IDLE;
      bit_r <= `PRT_BIT_LAST;
      sclk_r <= 1'b0;
      sdata_r <= 1'b0;
      le_r <= 1'b1;
      done_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        PRT_IDLE:
        begin
          if (wr_go)
          begin
            le_r <= 1'b0;
            sdata_r <= data_r[`PRT_BIT_LAST];
            bit_r <= `PRT_BIT_LAST;
            done_r <= 1'b0;
            state_r <= PRT_LOW;
          end
        end
        PRT_LOW:
        begin
          // data settled while sclk low, now raise it
          if (tick)
          begin
            sclk_r <= 1'b1;
            state_r <= PRT_SHIFT;
          end
        end
        PRT_SHIFT:
        begin
          if (tick)
          begin
            sclk_r <= 1'b0;
            if (bit_r == 5'h00)
              state_r <= PRT_RAISE;
            else
            begin
              bit_r <= bit_r - 5'h01;
              sdata_r <= data_r[bit_r - 5'h01];
              state_r <= PRT_LOW;
            end
          end
        end
        PRT_RAISE:
        begin
          // strobe rises only after the fourth byte
          if (tick)
          begin
            le_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= PRT_IDLE;
          end
        end
        default:
          state_r <= PRT_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.sdata = sdata_r;
  assign link.load_strobe = le_r;

endmodule : prt_host
`default_nettype wire
